/* File: design/stepper_driver_config_status.sv */
`timescale 1ns/100ps
`include "stepper_driver_params.svh"

// Overview of operation
// - three starts split table into four segments
// - width code maps table bit to increment
// - set bit ignores ground shorts
// - nonzero sync divides clock by N*64 below high speed
// - high speed forces off-time mode, doubled off
// - fullstep switching only at 45 degree position
// - blank comparator 16/24/36/54 clocks after switching
// - mode bit picks hysteresis or off-time chopper
// - random off time adds -12 to +3
// - optionally comparator never ends off-time mode fast decay
// - low hysteresis or sine offset, -3..12
// - start adds 1..8, decrement every 16
// - fast decay 32 clocks per count
// - off time 12+32*N, zero disables driver
// - filter updates measurement every four fullsteps
// - stall threshold is signed -64..+63
// - step down rate and current floor
// - increase below lower*32, zero disables
// - ground short disables driver, sticky flags
// - overtemp limit holds off until warning clears
// - stall on zero, standstill reports on-time
// - status standstill, fullstep, informative open load
module stepper_driver_config_status
	import stepper_driver_pkg::*;
#(
	parameter logic [6:0] MOTOR_OFFSET = 7'h00
) (
	// clock and reset
	input  wire logic               clk,
	input  wire logic               sys_rst,
	// register port
	input  wire logic [6:0]         reg_addr,
	input  wire logic [31:0]        reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	output logic [31:0]             reg_rdata,
	// microstep table
	input  wire logic [7:0]         table_index,
	input  wire logic               table_bit,
	output logic signed [2:0]       table_increment,
	// motion state
	input  wire logic               above_high_speed_threshold,
	input  wire logic               at_45_position,
	input  wire logic               fullstep_tick,
	input  wire logic               standstill,
	// chopper
	input  wire logic               comp_target,
	input  wire logic               comp_negative,
	output chop_phase_t             chop_phase,
	output logic                    bridges_enabled,
	output logic                    comp_blanked,
	output logic signed [5:0]       hysteresis_level,
	output logic signed [4:0]       sine_offset,
	output logic                    fullstep_active,
	// load measurement and current control
	input  wire logic               load_measure_valid,
	input  wire logic [9:0]         load_result_in,
	input  wire logic [9:0]         coil_a_ontime,
	input  wire logic [4:0]         run_current_scale,
	output logic signed [6:0]       stall_threshold,
	output logic [4:0]              current_scale_actual,
	// faults
	input  wire logic               ground_short_a_det,
	input  wire logic               ground_short_b_det,
	input  wire logic               open_load_a,
	input  wire logic               open_load_b,
	input  wire logic               overtemp_warn,
	input  wire logic               overtemp_limit,
	input  wire logic               driver_enable_low_pin
);

	function automatic logic signed [2:0] seg_increment(input logic [7:0] idx,
			input logic bit_v, input segment_map_t m);
		logic [1:0] code;
		code = m.width_code_seg_zero;
		if (idx >= m.seg3_start) begin
			code = m.width_code_seg_three;
		end else if (idx >= m.seg2_start) begin
			code = m.width_code_seg_two;
		end else if (idx >= m.seg1_start) begin
			code = m.width_code_seg_one;
		end
		return $signed({1'b0, code}) - 3'sd1 + $signed({2'b00, bit_v});
	endfunction

	function automatic logic [5:0] blank_clocks(input logic [1:0] code);
		unique case (code)
			2'd0: return `BLANK_CLK_CODE0;
			2'd1: return `BLANK_CLK_CODE1;
			2'd2: return `BLANK_CLK_CODE2;
			2'd3: return `BLANK_CLK_CODE3;
		endcase
	endfunction

	segment_map_t   seg_map_q;
	chopper_setup_t chop_q;
	energy_setup_t  energy_q;
	driver_state_t  state_word;
	chop_phase_t    phase_q;
	chop_phase_t    phase_d;
	logic [31:0]    rdata_q;
	logic [15:0]    lfsr_q;
	logic [9:0]     sync_cnt_q;
	logic           sync_tick_q;
	logic           ground_short_a_q;
	logic           ground_short_b_q;
	logic           overtemp_limit_flag_q;
	logic           fs_active_q;
	logic [3:0]     hyst_div_q;
	logic signed [5:0] hyst_q;
	logic [1:0]     fs_cnt_q;
	logic           quad_due_q;
	logic [9:0]     load_measure_value_q;
	logic [4:0]     cs_q;
	logic [4:0]     dn_cnt_q;
	logic signed [2:0] incr_q;
	logic           bridges_q;

	// register access
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			seg_map_q <= `RST_TABLE_SEGMENT_MAP;
			chop_q    <= `RST_CHOPPER_SETUP;
			energy_q  <= `RST_ENERGY_CONTROL_SETUP;
		end else if (reg_wr) begin
			if (reg_addr == `OFS_TABLE_SEGMENT_MAP + MOTOR_OFFSET) begin
				seg_map_q <= reg_wdata;
			end
			if (reg_addr == `OFS_CHOPPER_SETUP + MOTOR_OFFSET) begin
				chop_q <= reg_wdata;
			end
			if (reg_addr == `OFS_ENERGY_CONTROL_SETUP + MOTOR_OFFSET) begin
				energy_q <= reg_wdata[`ENERGY_SETUP_WIDTH-1:0];
			end
		end
	end

	// write-only registers and unmapped addresses read as zero
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			rdata_q <= '0;
		end else if (reg_rd) begin
			if (reg_addr == `OFS_CHOPPER_SETUP + MOTOR_OFFSET) begin
				rdata_q <= chop_q;
			end else if (reg_addr == `OFS_DRIVER_STATE_WORD + MOTOR_OFFSET) begin
				rdata_q <= state_word;
			end else begin
				rdata_q <= '0;
			end
		end
	end

	assign reg_rdata = rdata_q;

	// microstep increment for the current table position
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			incr_q <= '0;
		end else begin
			incr_q <= seg_increment(table_index, table_bit, seg_map_q);
		end
	end

	assign table_increment = incr_q;

	// derived chopper settings
	logic        high_speed;
	logic        eff_chm;
	logic [3:0]  fast_decay_length;
	logic [10:0] off_clocks;
	logic [10:0] fast_clocks;
	logic        sync_on;
	logic [9:0]  sync_period;
	logic        drive_ok;
	logic        blank_busy;
	logic        tmr_busy;
	logic        slow_release;
	logic signed [5:0] hyst_end;
	logic signed [5:0] hyst_begin;

	assign high_speed  = above_high_speed_threshold;
	assign eff_chm     = chop_q.chop_mode | (chop_q.high_speed_threshold_chopper & high_speed);
	assign fast_decay_length = (chop_q.high_speed_threshold_chopper & high_speed) ? 4'd0 :
		{chop_q.fast_msb, chop_q.hyst_start};
	assign fast_clocks = {2'b00, fast_decay_length, 5'b00000};
	always_comb begin
		off_clocks = `OFF_BASE_CLK + ((chop_q.high_speed_threshold_chopper & high_speed) ?
			{1'b0, chop_q.off_time, 6'b000000} :
			{2'b00, chop_q.off_time, 5'b00000});
		if (chop_q.random_off) begin
			off_clocks = off_clocks + {7'd0, lfsr_q[3:0]} - `RANDOM_OFF_BIAS;
		end
	end
	assign sync_on     = (chop_q.sync_div != 4'd0) && !high_speed;
	assign sync_period = {chop_q.sync_div, 6'b000000};
	assign slow_release = !sync_on || sync_tick_q;
	assign drive_ok    = (chop_q.off_time != 4'd0) && !driver_enable_low_pin &&
		!ground_short_a_q && !ground_short_b_q && !overtemp_limit_flag_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			lfsr_q <= 16'h0001;
		end else begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		end
	end

	// chopper synchronisation clock
	always_ff @(posedge clk) begin
		if (sys_rst || !sync_on) begin
			sync_cnt_q  <= '0;
			sync_tick_q <= 1'b0;
		end else if (sync_cnt_q >= sync_period - 10'd1) begin
			sync_cnt_q  <= '0;
			sync_tick_q <= 1'b1;
		end else begin
			sync_cnt_q  <= sync_cnt_q + 10'd1;
			sync_tick_q <= 1'b0;
		end
	end

	// chopper phase sequence
	always_comb begin
		phase_d = phase_q;
		if (!drive_ok) begin
			phase_d = CH_OFF;
		end else begin
			unique case (phase_q)
				CH_OFF: phase_d = CH_ON;
				CH_ON: begin
					if (!blank_busy && comp_target) begin
						phase_d = (eff_chm && fast_decay_length != 4'd0) ? CH_FAST : CH_SLOW;
					end
				end
				CH_FAST: begin
					if (eff_chm) begin
						if (!tmr_busy || (!chop_q.fast_cmp_disable && !blank_busy &&
								comp_negative)) begin
							phase_d = CH_SLOW;
						end
					end else if (!blank_busy && comp_negative) begin
						phase_d = CH_SLOW2;
					end
				end
				CH_SLOW: begin
					if (!tmr_busy && slow_release) begin
						phase_d = eff_chm ? CH_ON : CH_FAST;
					end
				end
				CH_SLOW2: begin
					if (!tmr_busy && slow_release) begin
						phase_d = CH_ON;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_q   <= CH_OFF;
			bridges_q <= 1'b0;
		end else begin
			phase_q   <= phase_d;
			bridges_q <= (phase_d != CH_OFF);
		end
	end

	chopper_phase_timer #(
		.WIDTH (11)
	) u_phase_timer (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.load       (phase_d != phase_q),
		// the load edge is the first clock of the new phase
		.load_value (((phase_d == CH_FAST) ? fast_clocks : off_clocks) - 11'd1),
		.busy       (tmr_busy)
	);

	chopper_phase_timer #(
		.WIDTH (6)
	) u_blank_timer (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.load       ((phase_d != phase_q) && (phase_d != CH_OFF)),
		.load_value (blank_clocks(chop_q.blank_code)),
		.busy       (blank_busy)
	);

	assign chop_phase      = phase_q;
	assign bridges_enabled = bridges_q;
	assign comp_blanked    = blank_busy;

	// hysteresis: reloaded at each on phase, decays toward the low value
	assign hyst_end   = $signed({2'b00, chop_q.hyst_low}) - `HYST_END_BIAS;
	assign hyst_begin = hyst_end + $signed({3'b000, chop_q.hyst_start}) + 6'sd1;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			hyst_q     <= '0;
			hyst_div_q <= '0;
		end else if (phase_d == CH_ON && phase_q != CH_ON) begin
			hyst_q     <= hyst_begin;
			hyst_div_q <= '0;
		end else begin
			hyst_div_q <= hyst_div_q + 4'd1;
			if (hyst_div_q == 4'(`HYST_DEC_PERIOD_CLK - 5'd1) && hyst_q > hyst_end) begin
				hyst_q <= hyst_q - 6'sd1;
			end
		end
	end

	assign hysteresis_level = eff_chm ? 6'sd0 : hyst_q;
	assign sine_offset      = eff_chm ? hyst_end[4:0] : 5'sd0;

	// fullstep switching happens only at the 45 degree table position
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fs_active_q <= 1'b0;
		end else if (at_45_position) begin
			fs_active_q <= chop_q.high_speed_threshold_fullstep & high_speed;
		end
	end

	assign fullstep_active = fs_active_q;

	// measurement filter over four fullsteps
	logic sg_update;

	assign sg_update = load_measure_valid && (!energy_q.filter_en || quad_due_q);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fs_cnt_q   <= '0;
			quad_due_q <= 1'b0;
		end else begin
			if (fullstep_tick) begin
				fs_cnt_q <= fs_cnt_q + 2'd1;
			end
			if (fullstep_tick && fs_cnt_q == `FILTER_FULLSTEPS_M1) begin
				quad_due_q <= 1'b1;
			end else if (sg_update) begin
				quad_due_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			load_measure_value_q <= '0;
		end else if (sg_update) begin
			load_measure_value_q <= load_result_in;
		end
	end

	// adaptive current control
	logic        cool_on;
	logic [9:0]  lower_lim;
	logic [10:0] upper_lim;
	logic [5:0]  upper_sum;
	logic [4:0]  floor_cs;
	logic [5:0]  cs_up;
	logic [4:0]  dn_limit;

	assign cool_on   = (energy_q.lower_limit != 4'd0);
	assign lower_lim = {1'b0, energy_q.lower_limit, 5'b00000};
	assign upper_sum = {2'b00, energy_q.lower_limit} + {2'b00, energy_q.upper_span} + 6'd1;
	assign upper_lim = {upper_sum, 5'b00000};
	assign floor_cs  = energy_q.floor_quarter ? (run_current_scale >> 2) :
		(run_current_scale >> 1);
	assign cs_up     = {1'b0, cs_q} + 6'({5'd1} << energy_q.up_code);
	always_comb begin
		unique case (energy_q.down_code)
			2'd0: dn_limit = `DOWN_COUNT_CODE0;
			2'd1: dn_limit = `DOWN_COUNT_CODE1;
			2'd2: dn_limit = `DOWN_COUNT_CODE2;
			2'd3: dn_limit = `DOWN_COUNT_CODE3;
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cs_q     <= '0;
			dn_cnt_q <= '0;
		end else if (!cool_on || cs_q > run_current_scale) begin
			cs_q     <= run_current_scale;
			dn_cnt_q <= '0;
		end else if (sg_update) begin
			if (load_result_in < lower_lim) begin
				cs_q     <= (cs_up >= {1'b0, run_current_scale}) ?
					run_current_scale : cs_up[4:0];
				dn_cnt_q <= '0;
			end else if ({1'b0, load_result_in} >= upper_lim) begin
				if (dn_cnt_q >= dn_limit) begin
					dn_cnt_q <= '0;
					cs_q     <= (cs_q > floor_cs) ? cs_q - 5'd1 : floor_cs;
				end else begin
					dn_cnt_q <= dn_cnt_q + 5'd1;
				end
			end
		end
	end

	assign current_scale_actual = cs_q;
	assign stall_threshold      = $signed(energy_q.stall_thresh);

	// fault flags; a detection in the same cycle as a clear wins
	logic short_clear;

	assign short_clear = (chop_q.off_time == 4'd0) || driver_enable_low_pin;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ground_short_a_q <= 1'b0;
		end else if (ground_short_a_det && !chop_q.ground_short_protect_disable) begin
			ground_short_a_q <= 1'b1;
		end else if (short_clear) begin
			ground_short_a_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ground_short_b_q <= 1'b0;
		end else if (ground_short_b_det && !chop_q.ground_short_protect_disable) begin
			ground_short_b_q <= 1'b1;
		end else if (short_clear) begin
			ground_short_b_q <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			overtemp_limit_flag_q <= 1'b0;
		end else if (overtemp_limit) begin
			overtemp_limit_flag_q <= 1'b1;
		end else if (!overtemp_warn) begin
			overtemp_limit_flag_q <= 1'b0;
		end
	end

	// status word
	always_comb begin
		state_word                     = '0;
		state_word.standstill          = standstill;
		state_word.open_load_b         = open_load_b;
		state_word.open_load_a         = open_load_a;
		state_word.ground_short_b      = ground_short_b_q;
		state_word.ground_short_a      = ground_short_a_q;
		state_word.overtemp_warn       = overtemp_warn;
		state_word.overtemp_limit_flag = overtemp_limit_flag_q;
		state_word.stall               = (load_measure_value_q == '0);
		state_word.current_scale       = cs_q;
		state_word.fullstep_active     = fs_active_q;
		state_word.load_measure_value  = standstill ? coil_a_ontime :
			load_measure_value_q;
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	short_flag_set_a: assert property (
		ground_short_a_det && !chop_q.ground_short_protect_disable
		|=> ground_short_a_q ##1 !bridges_enabled) else $error("ground short not acted on");
	short_ignored_a: assert property (
		!ground_short_a_q && !ground_short_b_q && chop_q.ground_short_protect_disable
		|=> !ground_short_a_q && !ground_short_b_q)
		else $error("ground short acted on while disabled");
	off_disable_a: assert property (
		chop_q.off_time == 4'd0 && !reg_wr
		|=> chop_phase == CH_OFF) else $error("driver runs with zero off time");
	blank_after_switch_a: assert property (
		phase_q != $past(phase_q) && phase_q != CH_OFF
		|-> comp_blanked) else $error("comparator not blanked after switching");
	sync_tick_gate_a: assert property (
		sync_tick_q |-> $past(sync_on))
		else $error("sync pulse while sync is off");
	fullstep_pos_a: assert property (
		$changed(fs_active_q) |-> $past(at_45_position))
		else $error("fullstep switched off the 45 degree position");
	current_floor_a: assert property (
		cool_on && $past(cool_on) && $past(cs_q) >= floor_cs &&
		$stable(run_current_scale) && $stable(energy_q) |-> cs_q >= floor_cs)
		else $error("current below floor");
	current_up_a: assert property (
		sg_update && cool_on && load_result_in < lower_lim &&
		cs_q < run_current_scale && $stable(run_current_scale) |=> cs_q > $past(cs_q))
		else $error("current not raised on low load");
	filter_hold_a: assert property (
		energy_q.filter_en && load_measure_valid && !quad_due_q
		|=> $stable(load_measure_value_q)) else $error("filtered measurement updated early");
	overtemp_hold_a: assert property (
		overtemp_limit |=> overtemp_limit_flag_q ##1 !bridges_enabled)
		else $error("drivers not off at overtemp limit");

endmodule // stepper_driver_config_status

/* File: pkg/stepper_driver_params.svh */
`ifndef STEPPER_DRIVER_PARAMS_SVH
`define STEPPER_DRIVER_PARAMS_SVH

// register offsets of the first motor; the second motor adds the stride
`define OFS_TABLE_SEGMENT_MAP    7'h68
`define OFS_CHOPPER_SETUP        7'h6c
`define OFS_ENERGY_CONTROL_SETUP 7'h6d
`define OFS_DRIVER_STATE_WORD    7'h6f
`define MOTOR_STRIDE             7'h10

// reset values
`define RST_TABLE_SEGMENT_MAP    32'h0000_0000
`define RST_CHOPPER_SETUP        32'h0000_0000
`define RST_ENERGY_CONTROL_SETUP 25'h000_0000

// field widths and positions
`define ENERGY_SETUP_WIDTH       25
`define LOAD_WIDTH               10
`define LOAD_LIMIT_SHIFT         5
`define SYNC_PERIOD_SHIFT        6
`define OFF_TIME_SHIFT           5
`define FAST_DECAY_SHIFT         5

// chopper timing in system clocks
`define OFF_BASE_CLK             11'd12
`define RANDOM_OFF_BIAS          11'd12
`define BLANK_CLK_CODE0          6'd16
`define BLANK_CLK_CODE1          6'd24
`define BLANK_CLK_CODE2          6'd36
`define BLANK_CLK_CODE3          6'd54
`define HYST_DEC_PERIOD_CLK      5'd16
`define HYST_END_BIAS            6'sd3

// adaptive current down-step measurement counts, minus one
`define DOWN_COUNT_CODE0         5'd31
`define DOWN_COUNT_CODE1         5'd7
`define DOWN_COUNT_CODE2         5'd1
`define DOWN_COUNT_CODE3         5'd0

// fullsteps per filtered update, minus one
`define FILTER_FULLSTEPS_M1      2'd3

`endif

/* File: pkg/stepper_driver_pkg.sv */
package stepper_driver_pkg;

	typedef enum logic [2:0] {
		CH_OFF,
		CH_ON,
		CH_FAST,
		CH_SLOW,
		CH_SLOW2
	} chop_phase_t;

	typedef struct packed {
		logic [7:0] seg3_start;
		logic [7:0] seg2_start;
		logic [7:0] seg1_start;
		logic [1:0] width_code_seg_three;
		logic [1:0] width_code_seg_two;
		logic [1:0] width_code_seg_one;
		logic [1:0] width_code_seg_zero;
	} segment_map_t;

	typedef struct packed {
		logic       rsv31;
		logic       ground_short_protect_disable;
		logic [5:0] rsv29_24;
		logic [3:0] sync_div;
		logic       high_speed_threshold_chopper;
		logic       high_speed_threshold_fullstep;
		logic       sense_range;
		logic [1:0] blank_code;
		logic       chop_mode;
		logic       random_off;
		logic       fast_cmp_disable;
		logic       fast_msb;
		logic [3:0] hyst_low;
		logic [2:0] hyst_start;
		logic [3:0] off_time;
	} chopper_setup_t;

	typedef struct packed {
		logic       filter_en;
		logic       rsv23;
		logic [6:0] stall_thresh;
		logic       floor_quarter;
		logic [1:0] down_code;
		logic       rsv12;
		logic [3:0] upper_span;
		logic       rsv7;
		logic [1:0] up_code;
		logic       rsv4;
		logic [3:0] lower_limit;
	} energy_setup_t;

	typedef struct packed {
		logic       standstill;
		logic       open_load_b;
		logic       open_load_a;
		logic       ground_short_b;
		logic       ground_short_a;
		logic       overtemp_warn;
		logic       overtemp_limit_flag;
		logic       stall;
		logic [2:0] rsv23_21;
		logic [4:0] current_scale;
		logic       fullstep_active;
		logic [4:0] rsv14_10;
		logic [9:0] load_measure_value;
	} driver_state_t;

endpackage

/* File: design/chopper_phase_timer.sv */
`timescale 1ns/100ps

// loadable down counter that times one chopper interval
module chopper_phase_timer #(
	parameter int WIDTH = 11
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             sys_rst,
	// control
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] load_value,
	// status
	output logic                  busy
);

	logic [WIDTH-1:0] count_q;

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			count_q <= '0;
		end else if (load) begin
			count_q <= load_value;
		end else if (count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	assign busy = (count_q != '0);

endmodule // chopper_phase_timer

/* File: testbench/host_reg_model.sv */
`timescale 1ns/100ps

// host side of the register port: one strobed access per call
module host_reg_model (
	// clock
	input  wire logic        clk,
	// register port
	output logic [6:0]       reg_addr,
	output logic [31:0]      reg_wdata,
	output logic             reg_wr,
	output logic             reg_rd,
	input  wire logic [31:0] reg_rdata
);
	initial begin
		reg_addr = 7'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	task automatic write_reg(input logic [6:0] a, input logic [31:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk);
		#1;
		reg_wr = 1'b0;
		// released data no longer shows the last value
		reg_wdata = ~d;
	endtask

	task automatic read_reg(input logic [6:0] a, output logic [31:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk);
		#1;
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask
endmodule // host_reg_model

/* File: testbench/stepper_driver_config_status_test.sv */
`timescale 1ns/100ps

module stepper_driver_config_status_test
	import stepper_driver_pkg::*;
;
	logic clk = 1'b0, sys_rst = 1'b1;
	logic [6:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, rd;
	logic reg_wr, reg_rd;
	logic [7:0] t_idx = 8'h10;
	logic t_bit = 1'b0, hs = 1'b0, p45 = 1'b0, fs_tick = 1'b0, stst = 1'b0;
	logic c_tgt = 1'b0, c_neg = 1'b0, lm_v = 1'b0, gs_a = 1'b0, gs_b = 1'b0;
	logic ol_a = 1'b0, ol_b = 1'b0, ot_w = 1'b0, ot_l = 1'b0, en_low = 1'b0;
	logic [9:0] lm_in = 10'h3ff, ontime = 10'h155;
	logic [4:0] run_cs = 5'h13;
	logic signed [2:0] t_inc;
	logic signed [5:0] hyst;
	logic signed [4:0] s_ofs;
	logic signed [6:0] sg_thr;
	logic [4:0] cs_act;
	logic br_en, blanked, fs_act;
	chop_phase_t phase;
	int num_errors = 0, check_count = 0;

	always #50 clk = ~clk;

	host_reg_model host_u (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

	stepper_driver_config_status dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.table_index(t_idx), .table_bit(t_bit), .table_increment(t_inc),
		.above_high_speed_threshold(hs), .at_45_position(p45), .fullstep_tick(fs_tick),
		.standstill(stst), .comp_target(c_tgt), .comp_negative(c_neg), .chop_phase(phase),
		.bridges_enabled(br_en), .comp_blanked(blanked), .hysteresis_level(hyst),
		.sine_offset(s_ofs), .fullstep_active(fs_act), .load_measure_valid(lm_v),
		.load_result_in(lm_in), .coil_a_ontime(ontime), .run_current_scale(run_cs),
		.stall_threshold(sg_thr), .current_scale_actual(cs_act),
		.ground_short_a_det(gs_a), .ground_short_b_det(gs_b), .open_load_a(ol_a),
		.open_load_b(ol_b), .overtemp_warn(ot_w), .overtemp_limit(ot_l),
		.driver_enable_low_pin(en_low));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	task automatic meas(input logic [9:0] v);
		lm_in = v;
		lm_v = 1'b1;
		tick(1);
		lm_v = 1'b0;
		tick(1);
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_sim();
	end

	initial begin
		tick(12);
		sys_rst = 1'b0;
		check({31'h0, br_en}, 32'h0);
		// register access kinds
		host_u.write_reg(7'h6c, 32'h0001_4001);
		host_u.read_reg(7'h6c, rd);
		check(rd, 32'h0001_4001);
		host_u.write_reg(7'h68, 32'hc080_40e4);
		host_u.read_reg(7'h68, rd);
		check(rd, 32'h0);
		host_u.read_reg(7'h50, rd);
		check(rd, 32'h0);
		tick(3);
		check({31'h0, br_en}, 32'h1);
		$display("registers done");
		// width codes, segment 0
		for (int c = 0; c < 4; c++) begin
			host_u.write_reg(7'h68, {24'hc08040, 6'h0, 2'(c)});
			for (int b = 0; b < 2; b++) begin
				t_bit = b[0];
				tick(3);
				check({29'h0, t_inc}, {29'h0, 3'(c + b - 1)});
			end
		end
		// segment borders: segment 3 from its start, segment 2 just below
		host_u.write_reg(7'h68, 32'hc080_40c0);
		t_idx = 8'hc0;
		t_bit = 1'b1;
		tick(3);
		check({29'h0, t_inc}, 32'h3);
		t_idx = 8'hbf;
		tick(3);
		check({29'h0, t_inc}, 32'h0);
		// sine offset in off-time mode
		for (int c = 0; c < 16; c++) begin
			host_u.write_reg(7'h6c, 32'h0001_4001 | (c << 7));
			tick(2);
			check({27'h0, s_ofs}, {27'h0, 5'(c - 3)});
		end
		$display("table and offset done");
		// ground short
		gs_a = 1'b1;
		tick(2);
		gs_a = 1'b0;
		tick(3);
		check({31'h0, br_en}, 32'h0);
		host_u.read_reg(7'h6f, rd);
		check({31'h0, rd[27]}, 32'h1);
		en_low = 1'b1;
		tick(2);
		en_low = 1'b0;
		host_u.read_reg(7'h6f, rd);
		check({31'h0, rd[27]}, 32'h0);
		host_u.write_reg(7'h6c, 32'h4001_4001);
		gs_b = 1'b1;
		tick(4);
		check({31'h0, br_en}, 32'h1);
		gs_b = 1'b0;
		$display("short done");
		// overtemperature
		ot_w = 1'b1;
		ot_l = 1'b1;
		tick(2);
		ot_l = 1'b0;
		tick(3);
		check({31'h0, br_en}, 32'h0);
		host_u.read_reg(7'h6f, rd);
		check({30'h0, rd[26:25]}, 32'h3);
		ot_w = 1'b0;
		tick(4);
		check({31'h0, br_en}, 32'h1);
		$display("overtemp done");
		// hysteresis chopper: low 5, start 3
		host_u.write_reg(7'h6c, 32'h0001_02b1);
		en_low = 1'b1;
		tick(2);
		en_low = 1'b0;
		tick(2);
		check({26'h0, hyst}, 32'h6);
		tick(70);
		check({21'h0, hyst, s_ofs}, {21'h0, 6'h2, 5'h0});
		// off-time chopper with sync: blank 36, fast decay 32
		host_u.write_reg(7'h6c, 32'h0011_4011);
		en_low = 1'b1;
		tick(2);
		en_low = 1'b0;
		tick(36);
		check({31'h0, blanked}, 32'h1);
		tick(1);
		check({31'h0, blanked}, 32'h0);
		tick(5);
		c_tgt = 1'b1;
		tick(2);
		c_tgt = 1'b0;
		tick(30);
		check({29'h0, phase}, {29'h0, CH_FAST});
		tick(1);
		check({29'h0, phase}, {29'h0, CH_SLOW});
		// high speed: off-time mode and fullstep only at 45 degrees
		host_u.write_reg(7'h6c, 32'h000d_0011);
		hs = 1'b1;
		tick(3);
		check({31'h0, fs_act}, 32'h0);
		check({27'h0, s_ofs}, 32'h1d);
		p45 = 1'b1;
		tick(1);
		p45 = 1'b0;
		check({31'h0, fs_act}, 32'h1);
		host_u.read_reg(7'h6f, rd);
		check({31'h0, rd[15]}, 32'h1);
		hs = 1'b0;
		tick(3);
		check({31'h0, fs_act}, 32'h1);
		p45 = 1'b1;
		tick(1);
		p45 = 1'b0;
		check({31'h0, fs_act}, 32'h0);
		$display("chopper done");
		// status word
		stst = 1'b1;
		ol_a = 1'b1;
		tick(2);
		check({31'h0, br_en}, 32'h1);
		host_u.read_reg(7'h6f, rd);
		check({rd[31], rd[29], rd[20:16], rd[9:0]}, {2'b11, 5'h13, 10'h155});
		stst = 1'b0;
		// adaptive current: lower 1, span 0, down every value, floor half
		host_u.write_reg(7'h6d, 32'h0040_6001);
		check({25'h0, sg_thr}, 32'h40);
		repeat (12) meas(10'h100);
		check({27'h0, cs_act}, 32'h9);
		meas(10'h010);
		host_u.read_reg(7'h6f, rd);
		check({16'h0, rd[24], rd[20:16], rd[9:0]}, {16'h0, 1'b0, 5'h0a, 10'h010});
		meas(10'h000);
		host_u.read_reg(7'h6f, rd);
		check({21'h0, rd[24], rd[9:0]}, {21'h0, 1'b1, 10'h0});
		// filtered: no update until four fullsteps have passed
		host_u.write_reg(7'h6d, 32'h0140_6001);
		meas(10'h200);
		host_u.read_reg(7'h6f, rd);
		check({22'h0, rd[9:0]}, 32'h0);
		repeat (4) begin
			fs_tick = 1'b1;
			tick(1);
			fs_tick = 1'b0;
			tick(1);
		end
		meas(10'h200);
		host_u.read_reg(7'h6f, rd);
		check({21'h0, rd[24], rd[9:0]}, {21'h0, 1'b0, 10'h200});
		$display("status done");
		end_sim();
	end
endmodule // stepper_driver_config_status_test
